// *** design/sdtm_ctrl.sv ***
`timescale 1ns/1ps
// Summary of operation
// - activate to read/write waits row_to_column_delay code plus one cycles
// - after write end, activate held off precharge_time plus write_recovery_delay
// - write_recovery_delay acts only while synchronous DRAM is selected
// - write_recovery_delay codes 0..2 give 1..3 cycles; code 3 reserved
// - after auto-refresh, activate held off precharge_time plus refresh_activate_gap
// - refresh_activate_gap codes 0..3 give 2..5 cycles
// - bank_mode_select chooses bank-active or auto-precharge operation
// - bank_mode_select low means auto-precharge, row closed after each access
// - precharge_time gives 1..4 cycles, one less right after precharge
module sdtm_ctrl (
    input wire logic clk_sys,
    input wire logic rstn,
    input sdtm_pkg::sdtm_cfg_type cfg,
    input sdtm_pkg::sdtm_evt_type evt,
    output logic rw_allowed,
    output logic activate_allowed,
    output logic auto_precharge,
    output logic row_open,
    output logic cfg_reserved_err
);

    logic [3:0] rtc_val;
    logic [3:0] pre_eff;
    logic [1:0] wrec_code;
    logic [3:0] wr_val;
    logic [3:0] ref_val;
    logic [3:0] hold_val;
    logic hold_load;
    logic rtc_load;
    logic rtc_busy;
    logic hold_busy;
    logic [3:0] rtc_count;
    logic [3:0] hold_count;
    logic after_pre_q;
    logic after_pre_d;
    logic auto_pre_q;
    logic auto_pre_d;
    logic rsvd_q;
    logic rsvd_d;
    sdtm_pkg::sdtm_bank_type bank_q;
    sdtm_pkg::sdtm_bank_type bank_d;

    // widen a two-bit code and add its base
    function automatic logic [3:0] code_cycles(input logic [1:0] code, input logic [3:0] base);
        code_cycles = {2'h0, code} + base;
    endfunction

    // delay sums; the read/write counter loads N-1 so the command may go N cycles later
    always_comb
    begin
        rtc_val = code_cycles(cfg.row_to_column_delay, sdtm_pkg::RTC_BASE) - 4'h1;
        // one cycle shorter right after a precharge command
        pre_eff = code_cycles(cfg.precharge_time, sdtm_pkg::PRE_BASE)
            - {3'h0, after_pre_q};
        // reserved code must not be used; it is served as the longest legal one
        wrec_code = (cfg.write_recovery_delay == sdtm_pkg::WREC_RSVD) ?
            sdtm_pkg::WREC_MAX : cfg.write_recovery_delay;
        wr_val = pre_eff + code_cycles(wrec_code, sdtm_pkg::WREC_BASE);
        ref_val = pre_eff + code_cycles(cfg.refresh_activate_gap, sdtm_pkg::REF_GAP_BASE);
        hold_val = 4'h0;
        if (cfg.sdram_sel && evt.write_end)
            hold_val = wr_val;
        if (cfg.sdram_sel && evt.refresh && (ref_val > hold_val))
            hold_val = ref_val;
        hold_load = (hold_val != 4'h0);
        rtc_load = cfg.sdram_sel && evt.activate;
    end

    sdtm_timer #(
        .W(sdtm_pkg::CNT_W)
    ) u_rtc (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(rtc_load),
        .load_val(rtc_val),
        .busy(rtc_busy),
        .count(rtc_count)
    );

    sdtm_timer #(
        .W(sdtm_pkg::CNT_W)
    ) u_hold (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(hold_load),
        .load_val(hold_val),
        .busy(hold_busy),
        .count(hold_count)
    );

    // permission strobes are combinational so a blocked command never slips
    assign rw_allowed = !rtc_busy && !rtc_load;
    assign activate_allowed = !hold_busy && !hold_load;

    // precharge flag, bank state, mode and reserved-code flags
    always_comb
    begin
        after_pre_d = after_pre_q;
        if (evt.activate)
            after_pre_d = 1'b0;
        if (evt.precharge) // set wins over a coincident activate
            after_pre_d = 1'b1;
        auto_pre_d = (cfg.bank_mode_select == sdtm_pkg::MODE_AUTO_PRE);
        rsvd_d = cfg.sdram_sel && (cfg.write_recovery_delay == sdtm_pkg::WREC_RSVD);
        bank_d = bank_q;
        unique case (bank_q)
            sdtm_pkg::BANK_CLOSED:
            begin
                if (evt.activate)
                    bank_d = sdtm_pkg::BANK_OPEN;
            end
            sdtm_pkg::BANK_OPEN:
            begin
                // auto-precharge closes the row with every access
                if (evt.precharge || evt.refresh)
                    bank_d = sdtm_pkg::BANK_CLOSED;
                else if (evt.rw && (cfg.bank_mode_select == sdtm_pkg::MODE_AUTO_PRE))
                    bank_d = sdtm_pkg::BANK_CLOSED;
                else
                    bank_d = sdtm_pkg::BANK_OPEN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            after_pre_q <= sdtm_pkg::FLAG_RST;
            auto_pre_q <= sdtm_pkg::FLAG_RST;
            rsvd_q <= sdtm_pkg::FLAG_RST;
            bank_q <= sdtm_pkg::BANK_CLOSED;
        end
        else
        begin
            after_pre_q <= after_pre_d;
            auto_pre_q <= auto_pre_d;
            rsvd_q <= rsvd_d;
            bank_q <= bank_d;
        end
    end

    assign auto_precharge = auto_pre_q;
    assign row_open = (bank_q == sdtm_pkg::BANK_OPEN);
    assign cfg_reserved_err = rsvd_q;

    sequence act_slow_s;
        evt.activate && cfg.sdram_sel && (cfg.row_to_column_delay == 2'h3);
    endsequence

    sequence act_fast_s;
        evt.activate && cfg.sdram_sel && (cfg.row_to_column_delay == 2'h0);
    endsequence

    rtc_slow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_slow_s |-> !rw_allowed ##1 (!rw_allowed) [*3])
        else $error("read/write allowed inside the 4-cycle activate delay");

    rtc_fast_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_fast_s |=> (rw_allowed || evt.activate))
        else $error("read/write not allowed 1 cycle after activate");

    wr_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cfg.sdram_sel && evt.write_end) |=> (hold_count >= $past(wr_val)))
        else $error("write hold-off shorter than precharge plus recovery");

    wr_ignore_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        !cfg.sdram_sel |-> (hold_val == 4'h0))
        else $error("hold-off loaded without synchronous DRAM selected");

    wr_codes_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!after_pre_q && cfg.precharge_time == 2'h0 && cfg.write_recovery_delay == 2'h2)
        |-> (wr_val == 4'h4))
        else $error("write recovery code 2 not 3 cycles");

    rsvd_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cfg.sdram_sel && cfg.write_recovery_delay == 2'h3) |=> cfg_reserved_err)
        else $error("reserved write recovery code not flagged");

    ref_gap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cfg.sdram_sel && evt.refresh && !evt.write_end && !after_pre_q
         && cfg.precharge_time == 2'h3 && cfg.refresh_activate_gap == 2'h3)
        |-> (hold_val == 4'h9) ##1 (!activate_allowed) [*8])
        else $error("refresh hold-off not 9 cycles");

    pre_short_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (after_pre_q && cfg.precharge_time == 2'h1) |-> (pre_eff == 4'h1))
        else $error("precharge time not shortened after precharge");

    auto_close_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (row_open && evt.rw && !cfg.bank_mode_select) |=> (!row_open && auto_precharge))
        else $error("row left open in auto-precharge mode");

    bank_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (row_open && evt.rw && cfg.bank_mode_select && !evt.precharge && !evt.refresh)
        |=> (row_open && !auto_precharge))
        else $error("row closed in bank-active mode");

    sequence act_mid_s;
        evt.activate && cfg.sdram_sel && (cfg.row_to_column_delay == 2'h1) && !rtc_busy;
    endsequence

    // a fresh two-cycle delay frees read/write on its second cycle
    rtc_mid_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_mid_s |=> !rw_allowed ##1 (rw_allowed || evt.activate || $past(evt.activate)))
        else $error("read/write not allowed 2 cycles after activate");

    hold_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        hold_busy |=> (hold_count >= $past(hold_count) - 4'h1))
        else $error("running hold-off shortened by a later event");

    pre_set_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        evt.precharge |=> after_pre_q)
        else $error("precharge not remembered");

    pre_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (evt.activate && !evt.precharge) |=> !after_pre_q)
        else $error("precharge shortening kept past an activate");

    row_act_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        (evt.activate && !evt.rw && !evt.precharge && !evt.refresh) |=> row_open)
        else $error("activate left the row closed");

    mode_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
        1'b1 |=> (auto_precharge == ($past(cfg.bank_mode_select) == sdtm_pkg::MODE_AUTO_PRE)))
        else $error("page mode does not follow the bank mode bit");

endmodule // sdtm_ctrl

// *** design/sdtm_pkg.sv ***
package sdtm_pkg;

    // counter width; the longest hold is 4 + 5 = 9 cycles
    localparam int CNT_W = 4;

    // code-to-cycle offsets: cycles = code + base
    localparam logic [3:0] RTC_BASE = 4'h1;
    localparam logic [3:0] WREC_BASE = 4'h1;
    localparam logic [3:0] REF_GAP_BASE = 4'h2;
    localparam logic [3:0] PRE_BASE = 4'h1;

    // write-recovery code that software must not program
    localparam logic [1:0] WREC_RSVD = 2'h3;
    // reserved code is served as the longest legal setting
    localparam logic [1:0] WREC_MAX = 2'h2;

    // bank mode encoding
    localparam logic MODE_AUTO_PRE = 1'b0;
    localparam logic MODE_BANK_ACT = 1'b1;

    // reset values of the state held here
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic FLAG_RST = 1'b0;

    // timing and mode settings, written by software
    typedef struct packed {
        logic sdram_sel;
        logic [1:0] precharge_time;
        logic [1:0] row_to_column_delay;
        logic [1:0] write_recovery_delay;
        logic [1:0] refresh_activate_gap;
        logic bank_mode_select;
    } sdtm_cfg_type;

    // one-cycle command events from the command sequencer
    typedef struct packed {
        logic activate;
        logic rw;
        logic write_end;
        logic refresh;
        logic precharge;
    } sdtm_evt_type;

    typedef enum logic {
        BANK_CLOSED,
        BANK_OPEN
    } sdtm_bank_type;

endpackage

// *** design/sdtm_timer.sv ***
`timescale 1ns/1ps
// hold-off down-counter; a load never shortens a hold already running
module sdtm_timer #(
    parameter int W = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy,
    output logic [W-1:0] count
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic [W-1:0] dec;

    // the longest hold of nine cycles needs four bits
    if (W < 4)
    begin : g_w_check
        $error("sdtm_timer: W must be at least 4");
    end

    // count down to zero, take the longer of running and new hold
    always_comb
    begin
        dec = (count_q != '0) ? count_q - 1'b1 : count_q;
        count_d = dec;
        if (load && (load_val > dec))
            count_d = load_val;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            count_q <= '0;
        else
            count_q <= count_d;
    end

    assign busy = (count_q != '0);
    assign count = count_q;

endmodule // sdtm_timer

// *** sim/sdtm_mem_model.sv ***
`timescale 1ns/1ps
// command side of the memory: forwards the requested commands and counts any
// command issued while the controller had not yet permitted it
module sdtm_mem_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input sdtm_pkg::sdtm_evt_type cmd,
    input wire logic rw_allowed,
    input wire logic activate_allowed,
    output sdtm_pkg::sdtm_evt_type evt,
    output int violations
);
    // no reshaping of the pulses, so the bench fully owns command timing
    assign evt = cmd;

    // a memory would misbehave on an early command, so record it here
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            violations <= 0;
        else if ((evt.rw && !rw_allowed) || (evt.activate && !activate_allowed))
            violations <= violations + 1;
    end
endmodule // sdtm_mem_model

// *** sim/tb_sdtm_ctrl.sv ***
`timescale 1ns/1ps
module tb_sdtm_ctrl;
    localparam sdtm_pkg::sdtm_evt_type EV_ACT = 5'h10;
    localparam sdtm_pkg::sdtm_evt_type EV_RW = 5'h08;
    localparam sdtm_pkg::sdtm_evt_type EV_WE = 5'h04;
    localparam sdtm_pkg::sdtm_evt_type EV_REF = 5'h02;
    localparam sdtm_pkg::sdtm_evt_type EV_PRE = 5'h01;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    sdtm_pkg::sdtm_cfg_type cfg = '0;
    sdtm_pkg::sdtm_evt_type cmd = '0;
    sdtm_pkg::sdtm_evt_type evt;
    logic rw_allowed;
    logic activate_allowed;
    logic auto_precharge;
    logic row_open;
    logic cfg_reserved_err;
    int violations;
    int failures = 0;
    int n_tests = 0;

    // 20 MHz system clock
    always #25 clk_sys = ~clk_sys;

    sdtm_ctrl i_sdtm_ctrl (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg), .evt(evt),
        .rw_allowed(rw_allowed), .activate_allowed(activate_allowed),
        .auto_precharge(auto_precharge), .row_open(row_open),
        .cfg_reserved_err(cfg_reserved_err));

    sdtm_mem_model i_sdtm_mem_model (.clk_sys(clk_sys), .rstn(rstn), .cmd(cmd),
        .rw_allowed(rw_allowed), .activate_allowed(activate_allowed), .evt(evt),
        .violations(violations));

    task automatic check(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t ns: %s got %b expected %b", $time, m, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // settings change at the falling edge, like every other input
    task automatic set_cfg(input logic s, input logic [1:0] p, input logic [1:0] c,
        input logic [1:0] w, input logic [1:0] r, input logic m);
        @(negedge clk_sys);
        cfg = {s, p, c, w, r, m};
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
        cmd = '0;
    endtask

    // one-cycle command, then the watched permission must stay low for n
    // cycles after the sampling edge and come back in cycle n+1; the command
    // is withdrawn before each look, as a live event would hold it low itself
    task automatic hold(input sdtm_pkg::sdtm_evt_type e, input bit act, input int n);
        @(negedge clk_sys);
        cmd = e;
        for (int k = 1; k <= n + 1; k++)
        begin
            @(negedge clk_sys);
            cmd = '0;
            #1;
            check(act ? activate_allowed : rw_allowed, k > n, "permission timing");
        end
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        check(rw_allowed, 1'b1, "rw during reset");
        check(activate_allowed, 1'b1, "activate during reset");
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        idle(2);
        check(auto_precharge, 1'b1, "auto precharge after reset");
        check(row_open, 1'b0, "row closed after reset");
        check(cfg_reserved_err, 1'b0, "no reserved flag after reset");
        set_cfg(1'b1, 2'h0, 2'h0, 2'h0, 2'h0, 1'b1);
        idle(2);
        check(auto_precharge, 1'b0, "bank active mode");
        // every activate-to-command code; the row stays open in bank mode
        for (int c = 0; c < 4; c++)
        begin
            set_cfg(1'b1, 2'h0, c[1:0], 2'h0, 2'h0, 1'b1);
            hold(EV_ACT, 1'b0, c);
            hold(EV_RW, 1'b0, 0);
            check(row_open, 1'b1, "row kept open");
            idle(12);
        end
        // auto-precharge closes the row after the access; software picks it
        set_cfg(1'b1, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0);
        hold(EV_ACT, 1'b0, 0);
        hold(EV_RW, 1'b0, 0);
        check(row_open, 1'b0, "row closed by auto precharge");
        idle(12);
        // every precharge code with each legal write-recovery code 0..2
        for (int p = 0; p < 4; p++)
            for (int t = 0; t < 3; t++)
            begin
                set_cfg(1'b1, p[1:0], 2'h0, t[1:0], 2'h0, 1'b1);
                hold(EV_ACT, 1'b0, 0);
                hold(EV_WE, 1'b1, p + t + 2);
                idle(12);
            end
        set_cfg(1'b1, 2'h1, 2'h0, 2'h3, 2'h0, 1'b1);
        idle(2);
        check(cfg_reserved_err, 1'b1, "reserved code flagged");
        hold(EV_WE, 1'b1, 2 + 3);
        idle(12);
        for (int r = 0; r < 4; r++)
        begin
            set_cfg(1'b1, r[1:0], 2'h0, 2'h0, r[1:0], 1'b1);
            hold(EV_REF, 1'b1, (r + 1) + (r + 2));
            idle(12);
        end
        // a precharge shortens the following precharge time by one cycle
        set_cfg(1'b1, 2'h1, 2'h0, 2'h1, 2'h0, 1'b1);
        hold(EV_ACT, 1'b0, 0);
        @(negedge clk_sys);
        cmd = EV_PRE;
        idle(1);
        hold(EV_WE, 1'b1, 1 + 2);
        idle(12);
        hold(EV_ACT, 1'b0, 0);
        hold(EV_WE, 1'b1, 2 + 2);
        idle(12);
        // without synchronous memory every hold and the flag are ignored
        set_cfg(1'b0, 2'h3, 2'h3, 2'h3, 2'h3, 1'b1);
        idle(2);
        check(cfg_reserved_err, 1'b0, "flag ignored without sdram");
        hold(EV_WE, 1'b1, 0);
        hold(EV_REF, 1'b1, 0);
        hold(EV_ACT, 1'b0, 0);
        check(violations == 0, 1'b1, "command issued while held off");
        end_of_test;
    end

    // the whole sequence needs well under 1500 cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        end_of_test;
    end
endmodule // tb_sdtm_ctrl
